// *** inc/dtpwm_params.svh ***
`ifndef DTPWM_PARAMS_SVH
`define DTPWM_PARAMS_SVH
// ==================================================
// Register indices (byte address over four)
`define DTPWM_IDX_COUNT      3'd0
`define DTPWM_IDX_CTRL1      3'd1
`define DTPWM_IDX_CTRL2      3'd2
`define DTPWM_IDX_DUTY       3'd3
`define DTPWM_IDX_PSC        3'd4
`define DTPWM_IDX_HIGH       3'd5
`define DTPWM_IDX_STATUS     3'd6
// ==================================================
// Field positions
`define DTPWM_C1_RUN         0
`define DTPWM_C1_RELOAD      1
`define DTPWM_C1_ONESHOT     2
`define DTPWM_C1_POL         6
`define DTPWM_C1_PINEN       7
`define DTPWM_C2_PSDIS       3
`define DTPWM_C2_EDGE        4
`define DTPWM_C2_SRC         5
// ==================================================
// Reset values
`define DTPWM_RST_CTRL1      8'h00
`define DTPWM_RST_CTRL2      8'h3f
`define DTPWM_RST_PSC        8'hff
`define DTPWM_FULL_COUNT     10'h3ff
`define DTPWM_AXI_OKAY       2'b00
`define DTPWM_AXI_SLVERR     2'b10
`endif

// *** inc/dtpwm_pkg.sv ***
package dtpwm_pkg;
   // ==================================================
   // Configuration carried from register file to core
   typedef struct packed
   {
      logic       run;
      logic       reload_sel;
      logic       one_shot;
      logic       polarity;
      logic       pin_en;
      logic       src_ext;
      logic       edge_fall;
      logic       psc_dis_n;
      logic [2:0] psc_rate;
      logic [9:0] duty;
   } dtpwm_cfg_type;
   // Count-register load request
   typedef struct packed
   {
      logic       load;
      logic [9:0] value;
   } dtpwm_load_type;
endpackage

// *** verification/dtpwm_assertions.sv ***
`timescale 1ns/1ps
// ==================================================
// Port-level checks of the register bus and pin mux
module dtpwm_assertions
   import dtpwm_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic [4:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic [4:0]  s_axi_araddr_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        gpio_out_i,
   input wire logic        port_b_bit3_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==================================================
   // Shadow of the pin routing bit
   logic [4:0] addr_q;    // Address of the write under way
   logic       wd_q;      // Bit 7 of its data
   logic       bv_q;      // Response valid, one cycle late
   logic       pin_en_q;  // Routing bit, one cycle behind the block
   logic       pin_en_d;
   // Commit on the first cycle of a response; strobe assumed set
   assign pin_en_d = (s_axi_bvalid_o && !bv_q && addr_q == 5'h04) ? wd_q : pin_en_q;
   // Capture address and data as each is taken
   always_ff @(posedge clk_i)
   begin
      if (s_axi_awvalid_i && s_axi_awready_o) addr_q <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i[7];
   end
   // Shadow follows the reset of the block
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_en_q <= 1'b0;
         bv_q     <= 1'b0;
      end
      else
      begin
         pin_en_q <= pin_en_d;
         bv_q     <= s_axi_bvalid_o;
      end
   end
   // ==================================================
   // Assertions
   rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer not held");
   read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read answer late");
   read_byte_a:
      assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("read data above low byte");
   unmapped_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o
      && s_axi_araddr_i >= 5'h1c |=> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0)
      else $error("unmapped read not refused");
   mapped_okay_a: assert property (s_axi_arvalid_i && s_axi_arready_o
      && s_axi_araddr_i < 5'h1c |=> s_axi_rresp_o == 2'b00) else $error("mapped read refused");
   write_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken during response");
   write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
   gpio_route_a:
      assert property (!pin_en_q && !$past(pin_en_q) && !$past(sys_rst_i)
      |-> port_b_bit3_pin_o == $past(gpio_out_i)) else $error("pin not following gpio");
endmodule

bind dtpwm_top dtpwm_assertions i_chk
(
   .clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
   .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
   .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
   .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .gpio_out_i, .port_b_bit3_pin_o
);

// *** verification/dtpwm_ext_model.sv ***
`timescale 1ns/1ps
// ==================================================
// Far side: source on the external clock pin
module dtpwm_ext_model
(
   input  wire logic clk_i,
   output logic      ext_clk_o
);
   // Pin stands still until a transition is asked for
   initial ext_clk_o = 1'b0;
   // Move after an edge, then give the edge detector time
   task automatic move(input logic lvl);
      begin
         @(posedge clk_i);
         ext_clk_o <= lvl;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule

// *** verification/dtpwm_tb.sv ***
`timescale 1ns/1ps
// ==================================================
// Register-level bench of the down timer and PWM
module testbench
   import dtpwm_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  awa = 5'h00;
   logic [4:0]  ara = 5'h00;
   logic [31:0] wd = 32'h0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        br = 1'b0;
   logic        arv = 1'b0;
   logic        rr = 1'b0;
   logic        gpio = 1'b0;
   logic        awr, wrdy, bv, arr, rv, pin, ext;
   logic [1:0]  bresp, rresp, bq, rq;
   logic [31:0] rdat;
   logic [7:0]  d;
   int          errors = 0;
   int          checked = 0;
   int          cyc = 0;
   // PWM steps: address, data, expected pin
   logic [4:0]  pa [5] = '{5'h0c, 5'h04, 5'h04, 5'h0c, 5'h14};
   logic [7:0]  pv [5] = '{8'h60, 8'h80, 8'hc0, 8'h40, 8'h01};
   logic        pe [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   // 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   dtpwm_top i_dut
   (
      .clk_i(clk), .sys_rst_i(rst),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .external_clock_pin_i(ext),
      .gpio_out_i(gpio), .port_b_bit3_pin_o(pin)
   );
   dtpwm_ext_model i_ext (.clk_i(clk), .ext_clk_o(ext));
   // ==================================================
   // Closing report and hang guard
   task automatic stop_test();
      begin
         $display("checks %0d mismatches %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // The run needs under 2000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errors++;
         stop_test();
      end
   end
   // ==================================================
   // Bus tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      begin
         checked++;
         if (s !== e)
         begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      begin
         @(posedge clk);
         awa <= a;
         wd <= {24'h0, v};
         awv <= 1'b1;
         wv <= 1'b1;
         br <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
         end while (!bv);
         bq = bresp;
         br <= 1'b0;
      end
   endtask
   // Ready raised late so the answer must stand
   task automatic rd(input logic [4:0] a);
      begin
         @(posedge clk);
         ara <= a;
         arv <= 1'b1;
         do
         begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
         end while (!rv);
         rr <= 1'b1;
         @(posedge clk);
         d = rdat[7:0];
         rq = rresp;
         rr <= 1'b0;
      end
   endtask
   task automatic rc(input string n, input logic [4:0] a, input logic [7:0] e);
      begin
         rd(a);
         chk(n, e, d);
         chk("rresp", (a >= 5'h1c) ? 8'h02 : 8'h00, {6'h0, rq});
      end
   endtask
   task automatic run(input logic [7:0] c, input int n);
      begin
         wr(5'h04, c | 8'h01);
         repeat (n) @(posedge clk);
         wr(5'h04, c);
      end
   endtask
   // ==================================================
   // Test sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc("ctrl1", 5'h04, 8'h00);
      rc("ctrl2", 5'h08, 8'h3f);
      rc("count", 5'h00, 8'hff);
      rc("high", 5'h14, 8'h00);
      wr(5'h10, 8'h00);
      rc("psc", 5'h10, 8'hff);
      rc("duty", 5'h0c, 8'h00);
      rc("hole", 5'h1c, 8'h00);
      wr(5'h1c, 8'h00);
      chk("bresp", 8'h02, {6'h0, bq});
      $display("test reset done");
      wr(5'h14, 8'h10);
      wr(5'h00, 8'h20);
      repeat (5) @(posedge clk);
      rc("load", 5'h00, 8'h20);
      rc("status", 5'h18, 8'h04);
      wr(5'h14, 8'h00);
      $display("test load done");
      wr(5'h08, 8'h08);
      wr(5'h00, 8'h50);
      run(8'h00, 20);
      rd(5'h00);
      chk("direct", 8'h01, 8'(d >= 8'h28 && d <= 8'h3c));
      wr(5'h08, 8'h0f);
      wr(5'h08, 8'h07);
      wr(5'h00, 8'h50);
      run(8'h00, 20);
      rc("slow", 5'h00, 8'h50);
      rd(5'h10);
      chk("psc", 8'h01, 8'(d >= 8'hd0 && d < 8'hff));
      wr(5'h08, 8'h08);
      wr(5'h08, 8'h00);
      wr(5'h00, 8'h50);
      run(8'h00, 20);
      rd(5'h00);
      chk("half", 8'h01, 8'(d >= 8'h40 && d <= 8'h4a));
      $display("test prescaler done");
      wr(5'h08, 8'h08);
      wr(5'h00, 8'h03);
      run(8'h00, 20);
      rd(5'h18);
      chk("wrap", 8'h0d, d & 8'h0d);
      wr(5'h18, 8'h01);
      rc("clear", 5'h18, 8'h0c);
      wr(5'h00, 8'h03);
      run(8'h02, 20);
      rd(5'h18);
      chk("reload", 8'h01, d & 8'h0d);
      wr(5'h18, 8'h01);
      wr(5'h00, 8'h05);
      wr(5'h04, 8'h07);
      repeat (20) @(posedge clk);
      rc("oneshot", 5'h00, 8'h00);
      rd(5'h18);
      chk("done", 8'h02, d & 8'h0e);
      wr(5'h04, 8'h00);
      $display("test underflow done");
      wr(5'h08, 8'h28);
      wr(5'h00, 8'h80);
      wr(5'h04, 8'h01);
      i_ext.move(1'b1);
      wr(5'h04, 8'h00);
      i_ext.move(1'b0);
      rc("rise", 5'h00, 8'h7f);
      wr(5'h08, 8'h38);
      i_ext.move(1'b1);
      wr(5'h00, 8'h80);
      wr(5'h04, 8'h01);
      i_ext.move(1'b0);
      wr(5'h04, 8'h00);
      rc("fall", 5'h00, 8'h7f);
      $display("test external done");
      gpio <= 1'b1;
      repeat (3) @(posedge clk);
      chk("gpio", 8'h01, {7'h0, pin});
      gpio <= 1'b0;
      wr(5'h00, 8'h50);
      for (int i = 0; i < 5; i++)
      begin
         wr(pa[i], pv[i]);
         repeat (2) @(posedge clk);
         chk("pwm", {7'h0, pe[i]}, {7'h0, pin});
      end
      $display("test pwm done");
      stop_test();
   end
endmodule

// *** verilog/dtpwm_prescaler.sv ***
`timescale 1ns/1ps
// ==================================================
// Source edge select and 8-bit prescaler
module dtpwm_prescaler
   import dtpwm_pkg::*;
#(
   parameter int PSC_W = 8
)
(
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             run_i,
   input  wire logic             src_ext_i,
   input  wire logic             edge_fall_i,
   input  wire logic             psc_dis_n_i,
   input  wire logic [2:0]       rate_i,
   input  wire logic             ext_clk_i,
   output logic      [PSC_W-1:0] psc_count_o,
   output logic                  tick_o
);
`include "dtpwm_params.svh"
   // Elaboration check: the prescaler counter
   // spans eight bits, no more, no less
   if (PSC_W != 8)
   begin
      $error("Prescaler width must be 8");
   end
   logic             ext_prev_q;   // Last sample of the external pin
   logic [PSC_W-1:0] psc_q;        // Free prescaler counter, counts down
   logic [PSC_W-1:0] psc_d;
   wire              rise_w = ext_clk_i & ~ext_prev_q;
   wire              fall_w = ~ext_clk_i & ext_prev_q;
   // Pick source: instruction clock is every cycle
   wire              ext_edge_w = edge_fall_i ? fall_w : rise_w;
   wire              src_w      = src_ext_i ? ext_edge_w : 1'b1;
   // Division output: a wrap of the low rate+1 bits of the count
   wire [PSC_W-1:0]  mask_w     = PSC_W'((9'h002 << rate_i) - 9'h001);
   wire              wrap_w     = (psc_q & mask_w) == '0;
   assign psc_d       = psc_q - 8'h01;
   assign psc_count_o = psc_q;
   // Without prescaler every source event ticks the timer
   assign tick_o      = run_i & src_w & (psc_dis_n_i | wrap_w);
   // ==================================================
   // Edge history and prescaler counter
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ext_prev_q <= 1'b0;
         psc_q      <= `DTPWM_RST_PSC;
      end
      else
      begin
         ext_prev_q <= ext_clk_i;
         // Prescaler only steps while enabled and running
         if (run_i & src_w & ~psc_dis_n_i)
            psc_q <= psc_d;
      end
   end
endmodule

// *** verilog/dtpwm_pwm.sv ***
`timescale 1ns/1ps
// ==================================================
// PWM compare and pin mux
module dtpwm_pwm
   import dtpwm_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [9:0] count_i,
   input  wire logic [9:0] duty_i,
   input  wire logic       polarity_i,
   input  wire logic       pin_en_i,
   input  wire logic       gpio_out_i,
   output logic            pin_o
);
   logic pin_q;  // Registered pin level
   // Active while count at or below duty
   wire  act_w  = count_i <= duty_i;
   wire  lvl_w  = polarity_i ? ~act_w : act_w;
   wire  pin_d  = pin_en_i ? lvl_w : gpio_out_i;
   assign pin_o = pin_q;
   // ==================================================
   // Output flop
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         pin_q <= 1'b0;
      else
         pin_q <= pin_d;
   end
endmodule

// *** verilog/dtpwm_top.sv ***
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Function
// - 10-bit down counter, count register reads it
// - Count write loads reload and counter
// - Run bit gates counting
// - Non-stop, reload clear: reload 0x3FF
// - Non-stop, reload set: reload stored value
// - One-shot stops at underflow
// - Polarity bit one means active low
// - Pin enable routes PWM, else GPIO
// - Period from reload, duty from duty low and high bits
// - Rate field divides by two to 256
// - Prescaler enabled when disable bit zero
// - Edge bit one selects falling edges
// - Source bit one selects external pin
// - Prescaler count readable, writes ignored

// ==================================================
// Overview
// The 10-bit count steps down on a
// tick: every clock, or a sampled pin
// edge, divided or not.
// Each register is the low byte of a
// bus word; upper bits read as zero.
// The pin is registered, so it trails
// the count by one clock, glitch free.
// Underflow is sticky; writing one
// clears it, and a new underflow in
// the same cycle wins.
// PWM period is the reload period;
// duty is high bits 1:0 over duty low.

// ==================================================
// Limitations
// A rate change while the prescaler
// runs is not blocked; the next tick
// may come early or late.
// The pin is taken as synchronous;
// pulses under a clock may be missed.
// Only write strobe bit 0 is used.
module dtpwm_top
   import dtpwm_pkg::*;
(
   // Clock and synchronous reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Register bus, write channels
   input  wire logic [4:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // Register bus, read channels
   input  wire logic [4:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Far-side pins
   input  wire logic        external_clock_pin_i,
   input  wire logic        gpio_out_i,
   output logic             port_b_bit3_pin_o
);
`include "dtpwm_params.svh"

   // One clock domain, synchronous
   // reset: all state starts known.

   // Map, one byte per word: 0x00
   // count, 0x04 control one, 0x08
   // control two, 0x0c duty low, 0x10
   // prescaler count, 0x14 high bits,
   // 0x18 status.
   // ==================================================
   // Registers
   logic [7:0]    ctrl1_q;        // Run, reload, one-shot, polarity, pin enable
   logic [7:0]    ctrl2_q;        // Source, edge, prescaler disable, rate
   logic [7:0]    duty_lo_q;      // Low duty byte, write-only
   logic [7:0]    high_q;         // Shared high bits
   logic [9:0]    reload_q;       // Stored reload value
   logic [9:0]    count_q;        // Current count
   logic [9:0]    count_d;
   logic          done_q;         // One-shot has finished
   logic          uflow_q;        // Sticky underflow seen

   // Separate hold flags let address
   // and data arrive in either order.
   // Bus state
   logic          aw_hold_q;      // Write address captured
   logic          w_hold_q;       // Write data captured
   logic [2:0]    aw_idx_q;
   logic [31:0]   wdata_q;
   logic [3:0]    wstrb_q;
   logic          bvalid_q;
   logic [1:0]    bresp_q;
   logic          rvalid_q;
   logic [1:0]    rresp_q;
   logic [31:0]   rdata_q;

   // Links to the sub-blocks
   logic [7:0]    psc_w;          // Prescaler count
   logic          tick_w;         // Count enable pulse
   dtpwm_cfg_type cfg_w;          // Control fields
   dtpwm_load_type ld_w;          // Count write

   // ==================================================
   // Address decode helpers
   // Byte index from a word address; unmapped above status
   // Bits 1:0 are ignored, so an unaligned
   // access lands on its own word.
   function automatic logic [2:0] idx_of(input logic [4:0] a);
      idx_of = a[4:2];
   endfunction

   // Index 7 has no register: error reply
   function automatic logic mapped(input logic [4:0] a);
      mapped = (a[4:2] <= `DTPWM_IDX_STATUS);
   endfunction

   // ==================================================
   // Configuration bundle
   // One packed struct, so sub-blocks
   // see names, not bit positions.
   assign cfg_w.run        = ctrl1_q[`DTPWM_C1_RUN];
   assign cfg_w.reload_sel = ctrl1_q[`DTPWM_C1_RELOAD];
   assign cfg_w.one_shot   = ctrl1_q[`DTPWM_C1_ONESHOT];
   assign cfg_w.polarity   = ctrl1_q[`DTPWM_C1_POL];
   assign cfg_w.pin_en     = ctrl1_q[`DTPWM_C1_PINEN];
   assign cfg_w.src_ext    = ctrl2_q[`DTPWM_C2_SRC];
   assign cfg_w.edge_fall  = ctrl2_q[`DTPWM_C2_EDGE];
   assign cfg_w.psc_dis_n  = ctrl2_q[`DTPWM_C2_PSDIS];
   assign cfg_w.psc_rate   = ctrl2_q[2:0];
   assign cfg_w.duty       = {high_q[1:0], duty_lo_q};

   // ==================================================
   // Write path: address and data taken in either order
   // The response stands until bready;
   // new items are refused meanwhile,
   // so one write at most is open.
   wire           wr_go_w   = aw_hold_q & w_hold_q & ~bvalid_q;
   wire           wr_map_w  = aw_idx_q <= `DTPWM_IDX_STATUS;
   wire           wr_en_w   = wr_go_w & wr_map_w & wstrb_q[0];
   wire [7:0]     wbyte_w   = wdata_q[7:0];
   assign s_axi_awready_o = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready_o  = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   // Count write: byte plus high bits 5:4 go to reload and count
   assign ld_w.load  = wr_en_w & (aw_idx_q == `DTPWM_IDX_COUNT);
   assign ld_w.value = {high_q[5:4], wbyte_w};

   // ==================================================
   // Counter next value
   // A count write beats an underflow
   // reload, which beats a plain step;
   // a one-shot underflow stays at zero.
   wire           active_w  = cfg_w.run & ~done_q;
   wire           zero_w    = count_q == 10'h000;
   wire [9:0]     reld_w    = cfg_w.reload_sel ? reload_q : `DTPWM_FULL_COUNT;
   wire           step_w    = tick_w & active_w;
   wire           under_w   = step_w & zero_w;
   // Next count, held by default
   always_comb
   begin
      count_d = count_q;
      if (ld_w.load)
         count_d = ld_w.value;
      else if (under_w & ~cfg_w.one_shot)
         count_d = reld_w;
      else if (step_w & ~zero_w)
         count_d = count_q - 10'h001;
   end

   // ==================================================
   // Register file and counter
   // Control registers keep only their
   // defined bits; others read as zero.
   // Read-only registers drop writes.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl1_q   <= `DTPWM_RST_CTRL1;
         ctrl2_q   <= `DTPWM_RST_CTRL2;
         duty_lo_q <= 8'h00;
         high_q    <= 8'h00;
         reload_q  <= `DTPWM_FULL_COUNT;
         count_q   <= `DTPWM_FULL_COUNT;
         done_q    <= 1'b0;
         uflow_q   <= 1'b0;
      end
      else
      begin
         // Count takes its next value
         count_q <= count_d;
         // One-shot halts at zero regardless of reload select
         if (ld_w.load)
            done_q <= 1'b0;
         else if (under_w & cfg_w.one_shot)
            done_q <= 1'b1;
         // Underflow flag: set beats clear
         if (under_w)
            uflow_q <= 1'b1;
         else if (wr_en_w & (aw_idx_q == `DTPWM_IDX_STATUS) & wbyte_w[0])
            uflow_q <= 1'b0;
         // Only a count write sets reload
         if (ld_w.load)
            reload_q <= ld_w.value;
         if (wr_en_w)
         begin
            case (aw_idx_q)
               `DTPWM_IDX_CTRL1: ctrl1_q <= wbyte_w & 8'hc7;
               `DTPWM_IDX_CTRL2: ctrl2_q <= wbyte_w & 8'h3f;
               `DTPWM_IDX_DUTY:  duty_lo_q <= wbyte_w;
               `DTPWM_IDX_HIGH:  high_q <= wbyte_w;
               // Prescaler count ignores writes
               default: ;
            endcase
            // Clearing run re-arms a finished one-shot;
            // an underflow in the same cycle wins
            if ((aw_idx_q == `DTPWM_IDX_CTRL1) & ~wbyte_w[`DTPWM_C1_RUN] & ~under_w)
               done_q <= 1'b0;
         end
      end
   end

   // ==================================================
   // Write handshake
   // Readies are decoded, bvalid a flop.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_idx_q  <= 3'd0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `DTPWM_AXI_OKAY;
      end
      else
      begin
         // Address taken: index, 7 if unmapped
         if (s_axi_awvalid_i & s_axi_awready_o)
         begin
            aw_hold_q <= 1'b1;
            aw_idx_q  <= mapped(s_axi_awaddr_i) ? idx_of(s_axi_awaddr_i) : 3'd7;
         end
         // Data taken: word and strobes
         if (s_axi_wvalid_i & s_axi_wready_o)
         begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
         end
         // Both held: commit and answer
         if (wr_go_w)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map_w ? `DTPWM_AXI_OKAY : `DTPWM_AXI_SLVERR;
         end
         // Response taken: free the channels
         else if (bvalid_q & s_axi_bready_i)
            bvalid_q <= 1'b0;
      end
   end

   // ==================================================
   // Read path: one cycle to answer
   // The byte is latched as the address
   // is taken, so rdata stands still.
   // Unmapped reads give zero and error.
   wire [7:0] rbyte_w =
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_COUNT) ? count_q[7:0] :
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_CTRL1) ? ctrl1_q :
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_CTRL2) ? ctrl2_q :
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_PSC)   ? psc_w :
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_HIGH)  ? high_q :
      (idx_of(s_axi_araddr_i) == `DTPWM_IDX_STATUS) ?
         {4'h0, count_q[9:8], done_q, uflow_q} : 8'h00;
   // One read at a time: the address is
   // refused while the answer stands
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rresp_o   = rresp_q;
   assign s_axi_rdata_o   = rdata_q;
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `DTPWM_AXI_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      // Address taken: data and response
      else if (s_axi_arvalid_i & s_axi_arready_o)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= mapped(s_axi_araddr_i) ? `DTPWM_AXI_OKAY : `DTPWM_AXI_SLVERR;
         rdata_q  <= {24'h00_0000, rbyte_w};
      end
      // Answer taken
      else if (rvalid_q & s_axi_rready_i)
         rvalid_q <= 1'b0;
   end

   // ==================================================
   // Sub-blocks
   // Prescaler width matches the byte
   // wide prescaler count register.
   dtpwm_prescaler #(.PSC_W(8)) u_psc
   (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .run_i       (active_w),
      .src_ext_i   (cfg_w.src_ext),
      .edge_fall_i (cfg_w.edge_fall),
      .psc_dis_n_i (cfg_w.psc_dis_n),
      .rate_i      (cfg_w.psc_rate),
      .ext_clk_i   (external_clock_pin_i),
      .psc_count_o (psc_w),
      .tick_o      (tick_w)
   );
   dtpwm_pwm u_pwm
   (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .count_i    (count_q),
      .duty_i     (cfg_w.duty),
      .polarity_i (cfg_w.polarity),
      .pin_en_i   (cfg_w.pin_en),
      .gpio_out_i (gpio_out_i),
      .pin_o      (port_b_bit3_pin_o)
   );
endmodule
